// ### rtl/fsc_top.sv
/*
 * function-setting checker: holds cycle, control mode, gear, operating mode
 * and both mapping tables, flags unsupported combinations as one error.
 * assumes a host on the same clock using the plain strobe register port.
 */
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_top #(
   parameter int RX_DEPTH = 8,
   parameter int TX_DEPTH = 16
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire fsc_pkg::fsc_bus_req_s REG_REQ,
   output logic [31:0] REG_RDATA,
   output logic IRQ,
   output logic ERR_ACTIVE,
   output logic [7:0] ERR_MAIN,
   output logic [7:0] ERR_SUB
);
   import fsc_pkg::*;

   localparam int RXC_W = $clog2(RX_DEPTH + 1);
   localparam int TXC_W = $clog2(TX_DEPTH + 1);

   fsc_cfg_s cfg_q, cfg_d;
   logic [RXC_W-1:0] rx_cnt_q, rx_cnt_d;
   logic [TXC_W-1:0] tx_cnt_q, tx_cnt_d;
   logic [RX_DEPTH-1:0][15:0] rx_idx_q;
   logic [RX_DEPTH-1:0][7:0] rx_bits_q;
   logic [TX_DEPTH-1:0][15:0] tx_idx_q;
   logic [TX_DEPTH-1:0][7:0] tx_bits_q;
   logic [`FSC_STS_W-1:0] sts_q, sts_d, mask_q, mask_d;
   logic [`FSC_CAUSE_W-1:0] cause_q, cause_d;
   logic conflict_q, conflict_d, err_q, err_d, irq_q, irq_d;
   logic [7:0] main_q, main_d, sub_q, sub_d;
   logic [31:0] rdata_q, rdata_d;
   logic [11:0] rx_bytes;
   logic csp_mapped;
   logic wr, rd, clr_req, rx_page, tx_page;
   logic [5:0] slot;
   logic fast, c250, unity, pp_hm, hm;

   assign wr = REG_REQ.wr;
   assign rd = REG_REQ.rd;
   assign slot = REG_REQ.addr[7:2];
   assign rx_page = REG_REQ.addr[11:8] == `FSC_RX_PAGE;
   assign tx_page = REG_REQ.addr[11:8] == `FSC_TX_PAGE;
   assign clr_req = wr && REG_REQ.addr == `FSC_OFS_CTRL && REG_REQ.wdata[`FSC_CTRL_CLEAR];

   // mapping tables, one slot per entry
   for (genvar i = 0; i < RX_DEPTH; i++) begin : g_rx
      logic [23:0] ent_d;
      always_comb begin
         ent_d = {rx_idx_q[i], rx_bits_q[i]};
         if (wr && rx_page && slot == 6'(i)) begin
            ent_d = {REG_REQ.wdata[31:16], REG_REQ.wdata[7:0]};
         end
      end
      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            rx_idx_q[i] <= `FSC_RST_RX_IDX;
            rx_bits_q[i] <= `FSC_RST_BITS;
         end else begin
            rx_idx_q[i] <= ent_d[23:8];
            rx_bits_q[i] <= ent_d[7:0];
         end
      end
   end

   for (genvar i = 0; i < TX_DEPTH; i++) begin : g_tx
      logic [23:0] ent_d;
      always_comb begin
         ent_d = {tx_idx_q[i], tx_bits_q[i]};
         if (wr && tx_page && slot == 6'(i)) begin
            ent_d = {REG_REQ.wdata[31:16], REG_REQ.wdata[7:0]};
         end
      end
      always_ff @(posedge SYS_CLK) begin
         if (SYS_RST) begin
            tx_idx_q[i] <= `FSC_RST_TX_IDX;
            tx_bits_q[i] <= `FSC_RST_BITS;
         end else begin
            tx_idx_q[i] <= ent_d[23:8];
            tx_bits_q[i] <= ent_d[7:0];
         end
      end
   end

   // receive table: byte total; the index search is unused there
   fsc_map_scan #(.DEPTH(RX_DEPTH), .CW(RXC_W)) u_rx_scan (
      .count(rx_cnt_q),
      .obj_idx(rx_idx_q),
      .obj_bits(rx_bits_q),
      .find_idx(`FSC_OBJ_CSP_REF),
      .total_bytes(rx_bytes),
      .found()
   );

   // transmit table: looks for the cyclic position reference object
   fsc_map_scan #(.DEPTH(TX_DEPTH), .CW(TXC_W)) u_tx_scan (
      .count(tx_cnt_q),
      .obj_idx(tx_idx_q),
      .obj_bits(tx_bits_q),
      .find_idx(`FSC_OBJ_CSP_REF),
      .total_bytes(),
      .found(csp_mapped)
   );

   // configuration writes; counts saturate at the table depth
   always_comb begin
      cfg_d = cfg_q;
      rx_cnt_d = rx_cnt_q;
      tx_cnt_d = tx_cnt_q;
      mask_d = mask_q;
      if (wr) begin
         unique case (REG_REQ.addr)
            `FSC_OFS_MASK: mask_d = REG_REQ.wdata[`FSC_STS_W-1:0];
            `FSC_OFS_CYCLE: cfg_d.cycle = fsc_cycle_e'(REG_REQ.wdata[1:0]);
            `FSC_OFS_CLOSED: cfg_d.closed = REG_REQ.wdata[0];
            `FSC_OFS_GEAR_NUM: cfg_d.gear_num = REG_REQ.wdata;
            `FSC_OFS_GEAR_DEN: cfg_d.gear_den = REG_REQ.wdata;
            `FSC_OFS_OPMODE: cfg_d.opmode = REG_REQ.wdata[7:0];
            `FSC_OFS_RX_COUNT: begin
               rx_cnt_d = (REG_REQ.wdata > 32'(RX_DEPTH)) ? RXC_W'(RX_DEPTH) : REG_REQ.wdata[RXC_W-1:0];
            end
            `FSC_OFS_TX_COUNT: begin
               tx_cnt_d = (REG_REQ.wdata > 32'(TX_DEPTH)) ? TXC_W'(TX_DEPTH) : REG_REQ.wdata[TXC_W-1:0];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cfg_q <= '{FSC_CYC_1MS, 1'b0, `FSC_RST_GEAR, `FSC_RST_GEAR, `FSC_RST_OPMODE};
         rx_cnt_q <= RXC_W'(1);
         tx_cnt_q <= TXC_W'(1);
         mask_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         rx_cnt_q <= rx_cnt_d;
         tx_cnt_q <= tx_cnt_d;
         mask_q <= mask_d;
      end
   end

   // decoded setting terms
   assign fast = cfg_q.cycle == FSC_CYC_250US || cfg_q.cycle == FSC_CYC_500US;
   assign c250 = cfg_q.cycle == FSC_CYC_250US;
   assign unity = cfg_q.gear_num == cfg_q.gear_den;
   assign hm = cfg_q.opmode == `FSC_MODE_HM;
   assign pp_hm = hm || cfg_q.opmode == `FSC_MODE_PP;

   // conflict checks, recomputed every cycle so any change is seen
   always_comb begin
      cause_d[0] = !unity && fast;
      cause_d[1] = cfg_q.closed && c250;
      cause_d[2] = hm && fast;
      cause_d[3] = fast && rx_bytes > `FSC_RX_MAX_FAST;
      cause_d[4] = cfg_q.closed && rx_bytes > `FSC_RX_MAX_CLOSED;
      cause_d[5] = pp_hm && c250;
      cause_d[6] = pp_hm && cfg_q.cycle == FSC_CYC_1MS && cfg_q.closed && !unity;
      cause_d[7] = rx_bytes == 12'h000;
      cause_d[8] = {{(8 - TXC_W){1'b0}}, tx_cnt_q} >= 8'(`FSC_TX_MAX_OBJ);
      cause_d[9] = csp_mapped && (fast || !unity);
      conflict_d = |cause_d;
   end

   // error latch and interrupt status; a set always beats a clear
   always_comb begin
      err_d = conflict_q || (err_q && !clr_req);
      sts_d = sts_q;
      if (wr && REG_REQ.addr == `FSC_OFS_STATUS) begin
         sts_d = sts_q & ~REG_REQ.wdata[`FSC_STS_W-1:0];
      end
      if (conflict_d && !conflict_q) begin
         sts_d[`FSC_STS_CONFLICT] = 1'b1;
      end
      if (err_q && !err_d) begin
         sts_d[`FSC_STS_CLEARED] = 1'b1;
      end
      // next mask too, so a mask write or a clear shows on the pin at once
      irq_d = |(sts_d & mask_d);
      main_d = err_d ? `FSC_ERR_MAIN : 8'h00;
      sub_d = err_d ? `FSC_ERR_SUB : 8'h00;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cause_q <= '0;
         conflict_q <= 1'b0;
         err_q <= 1'b0;
         sts_q <= '0;
         irq_q <= 1'b0;
         main_q <= 8'h00;
         sub_q <= 8'h00;
      end else begin
         cause_q <= cause_d;
         conflict_q <= conflict_d;
         err_q <= err_d;
         sts_q <= sts_d;
         irq_q <= irq_d;
         main_q <= main_d;
         sub_q <= sub_d;
      end
   end

   // read mux; data stand one cycle only, unmapped reads give zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd) begin
         if (rx_page && slot < 6'(RX_DEPTH)) begin
            rdata_d = {rx_idx_q[slot[$clog2(RX_DEPTH)-1:0]], 8'h00, rx_bits_q[slot[$clog2(RX_DEPTH)-1:0]]};
         end else if (tx_page && slot < 6'(TX_DEPTH)) begin
            rdata_d = {tx_idx_q[slot[$clog2(TX_DEPTH)-1:0]], 8'h00, tx_bits_q[slot[$clog2(TX_DEPTH)-1:0]]};
         end else begin
            unique case (REG_REQ.addr)
               `FSC_OFS_STATUS: rdata_d[`FSC_STS_W-1:0] = sts_q;
               `FSC_OFS_MASK: rdata_d[`FSC_STS_W-1:0] = mask_q;
               `FSC_OFS_CYCLE: rdata_d[1:0] = cfg_q.cycle;
               `FSC_OFS_CLOSED: rdata_d[0] = cfg_q.closed;
               `FSC_OFS_GEAR_NUM: rdata_d = cfg_q.gear_num;
               `FSC_OFS_GEAR_DEN: rdata_d = cfg_q.gear_den;
               `FSC_OFS_OPMODE: rdata_d[7:0] = cfg_q.opmode;
               `FSC_OFS_RX_COUNT: rdata_d[RXC_W-1:0] = rx_cnt_q;
               `FSC_OFS_TX_COUNT: rdata_d[TXC_W-1:0] = tx_cnt_q;
               `FSC_OFS_ERR_STATE: begin
                  rdata_d = {2'b00, cause_q, sub_q[3:0], main_q, 6'h00, conflict_q, err_q};
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign IRQ = irq_q;
   assign ERR_ACTIVE = err_q;
   assign ERR_MAIN = main_q;
   assign ERR_SUB = sub_q;

   // checks on the design's own outputs and internal registers
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   chk_err_code_pair: assert property (ERR_ACTIVE |-> ERR_MAIN == 8'h93 && ERR_SUB == 8'h04)
      else $error("error active without code 93/4");
   chk_gear_fast_cycle: assert property (!unity && fast |=> conflict_q ##1 ERR_ACTIVE)
      else $error("non-unity gear at fast cycle not flagged");
   chk_closed_250us: assert property (cfg_q.closed && c250 |=> cause_q[1])
      else $error("fully-closed at 250 us not flagged");
   chk_homing_fast: assert property (hm && fast |=> cause_q[2] && $past(fast))
      else $error("homing at fast cycle not flagged");
   chk_rx_fast_size: assert property (fast && rx_bytes > 12'h014 |=> cause_q[3])
      else $error("large receive map at fast cycle not flagged");
   chk_rx_closed_size: assert property (cfg_q.closed && rx_bytes > 12'h00C |-> ##2 ERR_ACTIVE)
      else $error("receive map over 12 bytes under fully-closed not flagged");
   chk_pp_hm_250us: assert property (pp_hm && c250 |=> cause_q[5] ##1 ERR_ACTIVE)
      else $error("profile or homing at 250 us not flagged");
   chk_pp_hm_1ms: assert property (pp_hm && cfg_q.cycle == FSC_CYC_1MS && cfg_q.closed && !unity |=> cause_q[6])
      else $error("1 ms closed-loop gear case not flagged");
   chk_rx_empty_map: assert property (rx_cnt_q == '0 |=> cause_q[7] ##1 ERR_ACTIVE)
      else $error("empty receive map not flagged");
   chk_tx_obj_count: assert property (tx_cnt_q > TXC_W'(10) |=> cause_q[8])
      else $error("eleven transmit objects not flagged");
   chk_csp_ref_map: assert property (csp_mapped && !unity |=> cause_q[9])
      else $error("reference position map with gear not flagged");
   chk_err_hold: assert property (ERR_ACTIVE && conflict_q |=> ERR_ACTIVE)
      else $error("error dropped while conflict present");
   chk_err_release: assert property (ERR_ACTIVE && !conflict_q && clr_req |=> !ERR_ACTIVE && sts_q[1])
      else $error("clear without conflict did not release error");
   chk_irq_level: assert property (IRQ == |(sts_q & mask_q))
      else $error("interrupt low with unmasked status");

   cov_conflict_raise: cover property (!conflict_q ##1 conflict_q ##1 ERR_ACTIVE);
   cov_clear_done: cover property (ERR_ACTIVE ##1 !ERR_ACTIVE);
   cov_irq_seen: cover property ($rose(IRQ));
endmodule

// ### rtl/fsc_defs.svh
/*
 * register offsets, field positions, reset values and check limits of the
 * function-setting checker.
 * assumes a 12-bit byte address on the register port, one word per register.
 */
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

`define FSC_OFS_CTRL      12'h000
`define FSC_OFS_STATUS    12'h004
`define FSC_OFS_MASK      12'h008
`define FSC_OFS_CYCLE     12'h00C
`define FSC_OFS_CLOSED    12'h010
`define FSC_OFS_GEAR_NUM  12'h014
`define FSC_OFS_GEAR_DEN  12'h018
`define FSC_OFS_OPMODE    12'h01C
`define FSC_OFS_RX_COUNT  12'h020
`define FSC_OFS_TX_COUNT  12'h024
`define FSC_OFS_ERR_STATE 12'h028
`define FSC_RX_PAGE       4'h1
`define FSC_TX_PAGE       4'h2

`define FSC_CTRL_CLEAR    0
`define FSC_STS_CONFLICT  0
`define FSC_STS_CLEARED   1
`define FSC_STS_W         2
`define FSC_CAUSE_W       10
`define FSC_CAUSE_LSB     20

`define FSC_RST_GEAR      32'h0000_0001
`define FSC_RST_OPMODE    8'h08
`define FSC_RST_RX_IDX    16'h607A
`define FSC_RST_TX_IDX    16'h6064
`define FSC_RST_BITS      8'h20

`define FSC_MODE_PP       8'h01
`define FSC_MODE_HM       8'h06
`define FSC_RX_MAX_FAST   12'h014
`define FSC_RX_MAX_CLOSED 12'h00C
`define FSC_TX_MAX_OBJ    5'h0B
`define FSC_OBJ_CSP_REF   16'h4020
`define FSC_ERR_MAIN      8'h93
`define FSC_ERR_SUB       8'h04

`endif

// ### rtl/fsc_pkg.sv
/*
 * types of the function-setting checker.
 * assumes fsc_defs.svh carries every number.
 */
package fsc_pkg;

   // cycle code; all four codes are legal
   typedef enum logic [1:0] {
      FSC_CYC_250US = 2'b00,
      FSC_CYC_500US = 2'b01,
      FSC_CYC_1MS   = 2'b10,
      FSC_CYC_2MS   = 2'b11
   } fsc_cycle_e;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fsc_bus_req_s;

   typedef struct packed {
      fsc_cycle_e cycle;
      logic closed;
      logic [31:0] gear_num;
      logic [31:0] gear_den;
      logic [7:0] opmode;
   } fsc_cfg_s;

endpackage

// ### rtl/fsc_map_scan.sv
/*
 * combinational scan of one process-data mapping table: byte total of the
 * live entries and whether a given object index is among them.
 * assumes entries below count are live and the rest are ignored.
 */
`timescale 1ns/1ps
module fsc_map_scan #(
   parameter int DEPTH = 8,
   parameter int CW = 4
) (
   input wire logic [CW-1:0] count,
   input wire logic [DEPTH-1:0][15:0] obj_idx,
   input wire logic [DEPTH-1:0][7:0] obj_bits,
   input wire logic [15:0] find_idx,
   output logic [11:0] total_bytes,
   output logic found
);
   import fsc_pkg::*;

   logic [11:0] acc [0:DEPTH];
   logic [DEPTH-1:0] hit;

   assign acc[0] = 12'h000;

   // running bit total and index match, one stage per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic live;
      assign live = CW'(i) < count;
      assign acc[i+1] = acc[i] + (live ? {4'h0, obj_bits[i]} : 12'h000);
      assign hit[i] = live && (obj_idx[i] == find_idx);
   end

   // partial bytes count as a whole byte
   assign total_bytes = (acc[DEPTH] + 12'h007) >> 3;
   assign found = |hit;
endmodule

// ### sim/fsc_host_model.sv
/*
 * host controller model: writes and reads the checker's settings.
 * assumes the checker answers a read in the cycle after the strobe.
 */
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_host_model (
   input wire logic sys_clk,
   output fsc_pkg::fsc_bus_req_s reg_req,
   input wire logic [31:0] reg_rdata
);
   import fsc_pkg::*;

   // bus idle from time zero
   initial begin
      reg_req = '0;
   end

   // one-cycle write; the caller may pick legal or conflicting settings
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   // read data taken just after the edge that accepts the strobe
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
endmodule

// ### sim/tb_top.sv
/*
 * self-checking bench of the function-setting checker.
 * assumes the reset configuration is conflict free.
 */
`timescale 1ns/1ps
`include "fsc_defs.svh"
module tb_top;
   import fsc_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   fsc_bus_req_s reg_req;
   logic [31:0] reg_rdata;
   logic irq;
   logic err_active;
   logic [7:0] err_main;
   logic [7:0] err_sub;
   int err_count = 0;
   int checks_done = 0;

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   fsc_top i_fsc_top (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
      .IRQ(irq), .ERR_ACTIVE(err_active), .ERR_MAIN(err_main), .ERR_SUB(err_sub));
   fsc_host_model i_fsc_host_model (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic w(input logic [11:0] a, input logic [31:0] d);
      i_fsc_host_model.wr_reg(a, d);
   endtask

   // error outputs settle two cycles after the write is taken; two spare
   task automatic judge(input logic e);
      repeat (4) @(posedge sys_clk);
      #1;
      chk(32'(err_active), 32'(e));
      chk(32'(err_main), e ? 32'h93 : 32'h0);
      chk(32'(err_sub), e ? 32'h04 : 32'h0);
   endtask

   // back to the reset settings, then clear once the conflict is gone
   task automatic restore();
      w(`FSC_OFS_CYCLE, 32'h2);
      w(`FSC_OFS_CLOSED, 32'h0);
      w(`FSC_OFS_GEAR_NUM, 32'h1);
      w(`FSC_OFS_GEAR_DEN, 32'h1);
      w(`FSC_OFS_OPMODE, 32'h8);
      w(`FSC_OFS_RX_COUNT, 32'h1);
      w(`FSC_OFS_TX_COUNT, 32'h1);
      repeat (3) @(posedge sys_clk);
      w(`FSC_OFS_CTRL, 32'h1);
      judge(1'b0);
   endtask

   // pair of settings: first legal, second in conflict
   task automatic pair(input logic [11:0] a, input logic [31:0] ok, input logic [31:0] bad);
      w(a, ok);
      judge(1'b0);
      w(a, bad);
      judge(1'b1);
   endtask

   task automatic t_gear();
      w(`FSC_OFS_GEAR_NUM, 32'h2);
      pair(`FSC_OFS_CYCLE, 32'h2, 32'h1);
      restore();
   endtask

   task automatic t_closed();
      w(`FSC_OFS_CLOSED, 32'h1);
      pair(`FSC_OFS_CYCLE, 32'h1, 32'h0);
      restore();
   endtask

   task automatic t_modes();
      w(`FSC_OFS_CYCLE, 32'h1);
      pair(`FSC_OFS_OPMODE, 32'h1, 32'h6);
      restore();
      w(`FSC_OFS_CYCLE, 32'h0);
      pair(`FSC_OFS_OPMODE, 32'h8, 32'h1);
      restore();
   endtask

   // four bytes per default entry: 20 and 12 are the boundaries
   task automatic t_rx_size();
      w(`FSC_OFS_CYCLE, 32'h1);
      pair(`FSC_OFS_RX_COUNT, 32'h5, 32'h6);
      restore();
      w(`FSC_OFS_CLOSED, 32'h1);
      pair(`FSC_OFS_RX_COUNT, 32'h3, 32'h4);
      restore();
      w(`FSC_OFS_RX_COUNT, 32'h0);
      judge(1'b1);
      restore();
   endtask

   task automatic t_combo();
      w(`FSC_OFS_OPMODE, 32'h6);
      w(`FSC_OFS_CLOSED, 32'h1);
      pair(`FSC_OFS_GEAR_NUM, 32'h1, 32'h3);
      restore();
   endtask

   task automatic t_tx();
      pair(`FSC_OFS_TX_COUNT, 32'hA, 32'hB);
      restore();
      w(12'h200, {16'h4020, 8'h00, 8'h20});
      pair(`FSC_OFS_GEAR_NUM, 32'h1, 32'h2);
      restore();
      w(`FSC_OFS_CYCLE, 32'h0);
      judge(1'b1);
      restore();
      w(12'h200, {16'h6064, 8'h00, 8'h20});
   endtask

   // clear during conflict is ignored; error holds until cleared
   task automatic t_clear();
      logic [31:0] d;
      w(`FSC_OFS_OPMODE, 32'h1);
      w(`FSC_OFS_CYCLE, 32'h0);
      judge(1'b1);
      // only the profile-at-250 us cause is live: cause bit 5 sits at bit 25
      i_fsc_host_model.rd_reg(`FSC_OFS_ERR_STATE, d);
      chk(d, 32'h0204_9303);
      w(`FSC_OFS_CTRL, 32'h1);
      judge(1'b1);
      w(`FSC_OFS_CYCLE, 32'h2);
      judge(1'b1);
      restore();
   endtask

   task automatic t_irq();
      logic [31:0] d;
      // earlier scenarios left both sticky bits set
      w(`FSC_OFS_STATUS, 32'h3);
      w(`FSC_OFS_MASK, 32'h1);
      w(`FSC_OFS_CLOSED, 32'h1);
      w(`FSC_OFS_CYCLE, 32'h0);
      judge(1'b1);
      chk(32'(irq), 32'h1);
      i_fsc_host_model.rd_reg(`FSC_OFS_STATUS, d);
      chk(d, 32'h1);
      w(`FSC_OFS_MASK, 32'h0);
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(irq), 32'h0);
      w(`FSC_OFS_MASK, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(irq), 32'h1);
      restore();
      i_fsc_host_model.rd_reg(`FSC_OFS_STATUS, d);
      chk(d, 32'h3);
      w(`FSC_OFS_STATUS, 32'h3);
      repeat (2) @(posedge sys_clk);
      #1 chk(32'(irq), 32'h0);
      i_fsc_host_model.rd_reg(`FSC_OFS_STATUS, d);
      chk(d, 32'h0);
      i_fsc_host_model.rd_reg(12'h3F0, d);
      chk(d, 32'h0);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      judge(1'b0);
      t_gear();
      t_closed();
      t_modes();
      t_rx_size();
      t_combo();
      t_tx();
      t_clear();
      t_irq();
      print_verdict();
   end

   // watchdog well past the expected five hundred or so cycles
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule
